// ---- core/cpk_key_decoder.sv ----
// Purpose: Configuration port decoder with entry and exit keys.
// Assumes: iow_i/ior_i are one-cycle strobes synchronous to sys_clk_i.
// Notes: Holds the global index, device number, port address and activate bits.
`timescale 1ns/1ps
`include "cpk_regs.svh"
module cpk_key_decoder
   import cpk_pkg::*;
#(
   parameter int NUM_LDEV = `CPK_NUM_LDEV
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Board straps and host reset pin
   input wire logic host_reset_in_i,
   input wire logic port_strap_select_i,
   // ISA bus
   input wire logic [15:0] isa_addr_i,
   input wire logic aen_i,
   input wire logic iow_i,
   input wire logic ior_i,
   input wire logic [7:0] isa_data_i,
   output logic [7:0] isa_data_o,
   output logic isa_data_oe_n_o,
   // Status
   output logic cfg_mode_o,
   output logic [7:0] ldev_num_o,
   output logic [NUM_LDEV-1:0] ldev_active_o
);
   cpk_state_t state_reg;
   logic [7:0] index_reg;
   logic [7:0] port_addr_low_reg;
   logic [7:0] port_addr_high_reg;
   logic [NUM_LDEV-1:0] act_reg;
   logic host_rst_d_reg;
   logic hit_cfg;
   logic hit_data;
   logic wr_cfg;
   logic wr_data;
   logic rd_data;
   logic rd_index;
   logic any_reset;
   logic [7:0] rd_next;
   cpk_io_if io ();

   assign io.addr = isa_addr_i;
   assign io.aen = aen_i;
   assign io.base = {port_addr_high_reg, port_addr_low_reg};
   assign hit_cfg = io.hit_cfg;
   assign hit_data = io.hit_data;

   cpk_port_match u_match (
      .io(io)
   );

   // The pin reset acts like rst_i for all control state except the port address, which reloads only when the pin falls
   assign any_reset = rst_i || host_reset_in_i;
   assign wr_cfg = iow_i && hit_cfg;
   assign wr_data = iow_i && hit_data && (state_reg == CPK_CFG);
   assign rd_index = ior_i && hit_cfg && (state_reg == CPK_CFG);
   assign rd_data = ior_i && hit_data && (state_reg == CPK_CFG);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         host_rst_d_reg <= 1'b0;
      end else begin
         host_rst_d_reg <= host_reset_in_i;
      end
   end

   // Key state machine
   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         state_reg <= CPK_RUN;
      end else begin
         case (state_reg)
            CPK_RUN: begin
               if (wr_cfg && isa_data_i == `CPK_KEY_ENTER) begin
                  state_reg <= CPK_CFG;
               end
            end
            CPK_CFG: begin
               if (wr_cfg && isa_data_i == `CPK_KEY_EXIT) begin
                  state_reg <= CPK_RUN;
               end
            end
            default: begin
               state_reg <= CPK_RUN;
            end
         endcase
      end
   end

   // Strap catch: power-on reset or falling host reset reloads the base
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || (host_rst_d_reg && !host_reset_in_i)) begin
         // Each byte is cut out of the 16-bit base on purpose
         port_addr_high_reg <= port_strap_select_i ? 8'(`CPK_BASE_STRAP1 >> 8)
                                                   : 8'(`CPK_BASE_STRAP0 >> 8);
         port_addr_low_reg <= port_strap_select_i ? 8'(`CPK_BASE_STRAP1)
                                                  : 8'(`CPK_BASE_STRAP0);
      end else if (wr_data && index_reg == `CPK_IDX_ADDR_LO) begin
         port_addr_low_reg <= isa_data_i;
      end else if (wr_data && index_reg == `CPK_IDX_ADDR_HI) begin
         port_addr_high_reg <= isa_data_i;
      end
   end

   // Index is written at the config port address while configuring
   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         index_reg <= 8'h00;
      end else if (wr_cfg && state_reg == CPK_CFG && isa_data_i != `CPK_KEY_EXIT) begin
         index_reg <= isa_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         ldev_num_o <= `CPK_LDN_RESET;
      end else if (wr_data && index_reg == `CPK_IDX_LDN) begin
         ldev_num_o <= isa_data_i;
      end
   end

   // Activate bit per logical device; only bit 0 of the data is meaningful
   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         act_reg <= '0;
      end else if (wr_data && index_reg == `CPK_IDX_ACTIVATE
                   && ldev_num_o < 8'(NUM_LDEV)) begin
         act_reg[ldev_num_o[$clog2(NUM_LDEV)-1:0]] <= isa_data_i[0];
      end
   end

   always_comb begin
      rd_next = 8'h00;
      if (rd_index) begin
         rd_next = index_reg;
      end else begin
         case (index_reg)
            `CPK_IDX_LDN: rd_next = ldev_num_o;
            `CPK_IDX_ADDR_LO: rd_next = port_addr_low_reg;
            `CPK_IDX_ADDR_HI: rd_next = port_addr_high_reg;
            `CPK_IDX_ACTIVATE: begin
               if (ldev_num_o < 8'(NUM_LDEV)) begin
                  rd_next = {7'h00, act_reg[ldev_num_o[$clog2(NUM_LDEV)-1:0]]};
               end
            end
            default: rd_next = 8'h00;
         endcase
      end
   end

   // Read data is registered; driven one cycle after the strobe, for one cycle
   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         isa_data_o <= 8'h00;
         isa_data_oe_n_o <= 1'b1;
      end else begin
         isa_data_o <= rd_next;
         isa_data_oe_n_o <= !(rd_index || rd_data);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (any_reset) begin
         cfg_mode_o <= 1'b0;
         ldev_active_o <= '0;
      end else begin
         cfg_mode_o <= (state_reg == CPK_CFG);
         ldev_active_o <= act_reg;
      end
   end

   // Checks
   run_after_reset_a: assert property (@(posedge sys_clk_i)
      rst_i |=> state_reg == CPK_RUN && act_reg == '0)
      else $error("not in run after reset");
   no_run_drive_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      $past(state_reg) == CPK_RUN && !$past(any_reset) |-> isa_data_oe_n_o)
      else $error("bus driven in run state");
   strap_base_a: assert property (@(posedge sys_clk_i)
      rst_i |=> {port_addr_high_reg, port_addr_low_reg}
         == ($past(port_strap_select_i) ? `CPK_BASE_STRAP1 : `CPK_BASE_STRAP0))
      else $error("strap base wrong");
   enter_key_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      state_reg == CPK_RUN && iow_i && !aen_i && isa_addr_i == io.base
      && isa_data_i == `CPK_KEY_ENTER |=> state_reg == CPK_CFG ##1 cfg_mode_o)
      else $error("entry key not taken");
   exit_key_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      state_reg == CPK_CFG && wr_cfg && isa_data_i == `CPK_KEY_EXIT
      |=> state_reg == CPK_RUN)
      else $error("exit key not taken");
   dma_ignore_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      aen_i |=> $stable(state_reg) && $stable(index_reg))
      else $error("dma cycle decoded");
   relocate_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      wr_data && index_reg == `CPK_IDX_ADDR_LO |=> port_addr_low_reg == $past(isa_data_i))
      else $error("port address low not updated");
   data_read_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      ior_i && !aen_i && state_reg == CPK_CFG && isa_addr_i == 16'(io.base + 16'h0001)
      |=> !isa_data_oe_n_o)
      else $error("data port read not answered");
   run_ignore_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      state_reg == CPK_RUN && wr_cfg && isa_data_i != `CPK_KEY_ENTER |=> state_reg == CPK_RUN)
      else $error("run state took a non key write");
   enter_c: cover property (@(posedge sys_clk_i) state_reg == CPK_RUN ##1 state_reg == CPK_CFG);
   exit_c: cover property (@(posedge sys_clk_i) state_reg == CPK_CFG ##1 state_reg == CPK_RUN);
   relocate_c: cover property (@(posedge sys_clk_i) wr_data && index_reg == `CPK_IDX_ADDR_HI);
   host_strap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      host_rst_d_reg && !host_reset_in_i |=> {port_addr_high_reg, port_addr_low_reg}
         == ($past(port_strap_select_i) ? `CPK_BASE_STRAP1 : `CPK_BASE_STRAP0))
      else $error("strap not caught on host reset");
   ldev_write_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      wr_data && index_reg == `CPK_IDX_LDN |=> ldev_num_o == $past(isa_data_i))
      else $error("logical device number not written");
   index_read_a: assert property (@(posedge sys_clk_i) disable iff (any_reset)
      rd_index |=> !isa_data_oe_n_o && isa_data_o == $past(index_reg))
      else $error("index port read not answered");
   // Any device, not only device 0, since software picks the number
   activate_c: cover property (@(posedge sys_clk_i) $rose(|ldev_active_o));
   dma_c: cover property (@(posedge sys_clk_i) aen_i && iow_i);
endmodule : cpk_key_decoder

// ---- core/cpk_regs.svh ----
// Purpose: Constants for the configuration port key decoder.
// Assumes: 16-bit ISA I/O addresses, 8-bit data.
// Notes: Index numbers other than the activate index are the global configuration register indices.
`ifndef CPK_REGS_SVH
`define CPK_REGS_SVH
`define CPK_BASE_STRAP0 16'h03f0
`define CPK_BASE_STRAP1 16'h0370
`define CPK_KEY_ENTER 8'h55
`define CPK_KEY_EXIT 8'haa
`define CPK_IDX_LDN 8'h07
`define CPK_IDX_ADDR_LO 8'h26
`define CPK_IDX_ADDR_HI 8'h27
`define CPK_LDN_RESET 8'h00
`define CPK_ACT_RESET 8'h00
`define CPK_IDX_ACTIVATE 8'h30
`define CPK_NUM_LDEV 16
`endif

// ---- core/cpk_pkg.sv ----
// Purpose: Types for the configuration port key decoder.
// Assumes: Nothing beyond the header.
// Notes: States are one-hot.
package cpk_pkg;
   typedef enum logic [1:0] {
      CPK_RUN = 2'b01,
      CPK_CFG = 2'b10
   } cpk_state_t;
endpackage : cpk_pkg

// ---- core/cpk_io_if.sv ----
// Purpose: Decoded I/O access between the decoder and the port matcher.
// Assumes: One access per cycle.
// Notes: Matcher looks at address and qualifiers only.
`timescale 1ns/1ps
interface cpk_io_if;
   logic [15:0] addr;
   logic aen;
   logic [15:0] base;
   logic hit_cfg;
   logic hit_data;
   modport dec (output addr, output aen, output base, input hit_cfg, input hit_data);
   modport match (input addr, input aen, input base, output hit_cfg, output hit_data);
endinterface : cpk_io_if

// ---- core/cpk_port_match.sv ----
// Purpose: Matches the I/O address against the config and data ports.
// Assumes: aen high marks a DMA cycle.
// Notes: Purely combinational.
`timescale 1ns/1ps
module cpk_port_match (
   cpk_io_if.match io
);
   assign io.hit_cfg = !io.aen && (io.addr == io.base);
   assign io.hit_data = !io.aen && (io.addr == 16'(io.base + 16'h0001));
endmodule : cpk_port_match

// ---- verif/cpk_host_model.sv ----
// Purpose: ISA host master issuing one-cycle I/O strobes.
// Assumes: Caller sends entry key, then register accesses, then exit key.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/1ps
module cpk_host_model (
   // Clock
   input wire logic sys_clk_i,
   // ISA bus
   output logic [15:0] isa_addr_o,
   output logic aen_o,
   output logic iow_o,
   output logic ior_o,
   output logic [7:0] isa_data_o,
   input wire logic [7:0] isa_data_i,
   input wire logic isa_data_oe_n_i
);
   initial begin
      isa_addr_o = 16'h0000;
      aen_o = 1'b0;
      iow_o = 1'b0;
      ior_o = 1'b0;
      isa_data_o = 8'h00;
   end
   // Callers keep key, index, data, exit order
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d, input logic dma);
      @(posedge sys_clk_i);
      isa_addr_o <= a;
      isa_data_o <= d;
      aen_o <= dma;
      iow_o <= 1'b1;
      @(posedge sys_clk_i);
      iow_o <= 1'b0;
      aen_o <= 1'b0;
      isa_addr_o <= ~a;
      isa_data_o <= ~d;
   endtask : io_wr
   // Looks a few cycles for the bus to be driven; seen stays low if not
   task automatic io_rd(input logic [15:0] a, output logic [7:0] got, output logic seen);
      @(posedge sys_clk_i);
      isa_addr_o <= a;
      ior_o <= 1'b1;
      @(posedge sys_clk_i);
      ior_o <= 1'b0;
      isa_addr_o <= ~a;
      seen = 1'b0;
      got = 8'h00;
      // Read data stands only for the cycle after the strobe edge
      repeat (3) begin
         #1;
         if (isa_data_oe_n_i === 1'b0 && !seen) begin
            seen = 1'b1;
            got = isa_data_i;
         end
         @(posedge sys_clk_i);
      end
   endtask : io_rd
endmodule : cpk_host_model

// ---- verif/tb_config_port_key_decoder.sv ----
// Purpose: Self-checking bench for the configuration key decoder.
// Assumes: Host model drives the ISA bus; bench drives reset and strap.
// Notes: Each scenario judges its own results.
`timescale 1ns/1ps
module tb_config_port_key_decoder;
   logic sys_clk_i, rst_i, host_reset_in_i, port_strap_select_i;
   logic [15:0] isa_addr;
   logic aen, iow, ior, data_oe_n, cfg_mode, seen;
   logic [7:0] wdata, rdata, ldev_num, got;
   logic [15:0] ldev_active;
   int errors = 0;
   int tests_run = 0;
   cpk_host_model host (.sys_clk_i(sys_clk_i), .isa_addr_o(isa_addr), .aen_o(aen),
      .iow_o(iow), .ior_o(ior), .isa_data_o(wdata), .isa_data_i(rdata),
      .isa_data_oe_n_i(data_oe_n));
   cpk_key_decoder #(.NUM_LDEV(16)) uut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .host_reset_in_i(host_reset_in_i), .port_strap_select_i(port_strap_select_i),
      .isa_addr_i(isa_addr), .aen_i(aen), .iow_i(iow), .ior_i(ior), .isa_data_i(wdata),
      .isa_data_o(rdata), .isa_data_oe_n_o(data_oe_n), .cfg_mode_o(cfg_mode),
      .ldev_num_o(ldev_num), .ldev_active_o(ldev_active));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic check(input logic [15:0] s, input logic [15:0] e, input string m);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, m, s, e);
      end
   endtask : check
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out
   // Writes a key and judges the mode two cycles later
   task automatic key(input logic [15:0] a, input logic [7:0] d, input logic dma, input logic e);
      host.io_wr(a, d, dma);
      repeat (2) @(posedge sys_clk_i);
      #1;
      check(16'(cfg_mode), 16'(e), "mode after key");
   endtask : key
   task automatic t_reset();
      check(16'(cfg_mode), 16'h0000, "mode");
      check(ldev_active, 16'h0000, "active");
      check(16'(data_oe_n), 16'h0001, "oe_n");
      $display("Test reset done");
   endtask : t_reset
   task automatic t_run_refuse();
      host.io_wr(16'h03f1, 8'h07, 1'b0);
      host.io_rd(16'h03f1, got, seen);
      check(16'(seen), 16'h0000, "data port read in run");
      host.io_rd(16'h03f0, got, seen);
      check(16'(seen), 16'h0000, "config port read in run");
      key(16'h03f0, 8'haa, 1'b0, 1'b0);
      key(16'h03f0, 8'h55, 1'b1, 1'b0);
      check(16'(ldev_num), 16'h0000, "ldev in run");
      $display("Test run refusal done");
   endtask : t_run_refuse
   task automatic t_ldev();
      key(16'h03f0, 8'h55, 1'b0, 1'b1);
      host.io_wr(16'h03f0, 8'h07, 1'b0);
      host.io_wr(16'h03f1, 8'h02, 1'b0);
      host.io_wr(16'h03f0, 8'h30, 1'b0);
      host.io_wr(16'h03f1, 8'h01, 1'b0);
      host.io_rd(16'h03f1, got, seen);
      check(16'(ldev_num), 16'h0002, "ldev number");
      check({7'h00, seen, got}, 16'h0101, "data port read");
      check(ldev_active, 16'h0004, "activate bit");
      key(16'h03f0, 8'haa, 1'b0, 1'b0);
      $display("Test logical device done");
   endtask : t_ldev
   task automatic t_strap();
      @(posedge sys_clk_i) port_strap_select_i <= 1'b1;
      @(posedge sys_clk_i) host_reset_in_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      host_reset_in_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      #1;
      check(ldev_active, 16'h0000, "active after host reset");
      check(16'(ldev_num), 16'h0000, "ldev after host reset");
      key(16'h03f0, 8'h55, 1'b0, 1'b0);
      key(16'h0370, 8'h55, 1'b0, 1'b1);
      key(16'h0370, 8'haa, 1'b0, 1'b0);
      $display("Test strap done");
   endtask : t_strap
   task automatic t_reloc();
      key(16'h0370, 8'h55, 1'b0, 1'b1);
      host.io_wr(16'h0370, 8'h26, 1'b0);
      host.io_wr(16'h0371, 8'h50, 1'b0);
      key(16'h0370, 8'haa, 1'b0, 1'b1);
      key(16'h0350, 8'haa, 1'b0, 1'b0);
      key(16'h0350, 8'h55, 1'b0, 1'b1);
      host.io_rd(16'h0350, got, seen);
      check({7'h00, seen, got}, 16'h0126, "index port read");
      host.io_wr(16'h0350, 8'h27, 1'b0);
      host.io_wr(16'h0351, 8'h02, 1'b1);
      host.io_rd(16'h0351, got, seen);
      check({7'h00, seen, got}, 16'h0103, "high byte after dma write");
      host.io_wr(16'h0351, 8'h02, 1'b0);
      key(16'h0250, 8'haa, 1'b0, 1'b0);
      $display("Test relocation done");
   endtask : t_reloc
   initial begin
      #100000;
      errors++;
      close_out();
   end
   initial begin
      rst_i = 1'b1;
      host_reset_in_i = 1'b0;
      port_strap_select_i = 1'b0;
      repeat (10) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      #1;
      t_reset();
      t_run_refuse();
      t_ldev();
      t_strap();
      t_reloc();
      close_out();
   end
endmodule : tb_config_port_key_decoder
